// [hdl/mlap_cfg.svh]
// Purpose: constants of the low accumulator port
// Assumes: 8-bit register space, byte addresses
// Notes:   offsets of neighbouring registers kept for the shared decode
`ifndef MLAP_CFG_SVH
`define MLAP_CFG_SVH
`define MLAP_ADDR_MULTIPLY_ONLY_X_OPERAND    8'he8
`define MLAP_ADDR_MULTIPLY_ONLY_Y_OPERAND    8'he9
`define MLAP_ADDR_MUL_DH   8'hea
`define MLAP_ADDR_MUL_DL   8'heb
`define MLAP_ADDR_ACC1_X   8'hec
`define MLAP_ADDR_ACC0_Y   8'hed
`define MLAP_ADDR_ACC3     8'hee
`define MLAP_ADDR_ACC2     8'hef
`define MLAP_ADDR_CLR_A    8'he6
`define MLAP_ADDR_CLR_B    8'he7
`define MLAP_OPND_RST      8'h00
`define MLAP_ACC_RST       32'h0000_0000
`define MLAP_PROD_RST      16'h0000
`define MLAP_RDATA_IDLE    8'h00
`define MLAP_BYTE0_LSB     5'h00
`define MLAP_BYTE1_LSB     5'h08
`define MLAP_BYTE2_LSB     5'h10
`define MLAP_BYTE3_LSB     5'h18
`endif

// [hdl/mlap_pkg.sv]
// Purpose: shared types of the low accumulator port
// Assumes: nothing beyond the constants header
// Notes:   operands and sums are two's complement
package mlap_pkg;
  typedef logic signed [7:0]  mlap_opnd_t;
  typedef logic signed [15:0] mlap_prod_t;
  typedef logic signed [31:0] mlap_acc_t;
endpackage : mlap_pkg

// [hdl/mlap_mult.sv]
// Purpose: signed 8x8 multiplier feeding product and accumulator
// Assumes: operands settle within the cycle
// Notes:   purely combinational
`timescale 1ns/10ps
module mlap_mult
  import mlap_pkg::*;
(
  // Operands
  input  wire mlap_opnd_t x,
  input  wire mlap_opnd_t y,
  // Result
  output wire mlap_prod_t prod
);
  // Widen first so the full signed product is kept
  assign prod = mlap_prod_t'(x) * mlap_prod_t'(y);
endmodule : mlap_mult

// [hdl/mlap_top.sv]
// Purpose: multiply-accumulate unit, low accumulator bytes as ports
// Assumes: one-cycle register writes and reads on the processor clock
// Notes:   upper bytes and product are exported for the rest of the unit
// How it works
// - Read first location gives accumulator bits 15..8
// - Write first location loads X operand
// - Read second location gives accumulator bits 7..0
// - Write second location loads Y operand
// - Accumulate-location write adds X times Y
// - X and Y registers shared with multiply
// - Either clear location zeroes whole accumulator
// - Signed 8-bit operands, signed 32-bit sum
`timescale 1ns/10ps
`include "mlap_cfg.svh"
module mlap_top
  import mlap_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  // Rest of the unit
  output mlap_prod_t      mul_product,
  output logic      [7:0] accum_third_byte,
  output logic      [7:0] accum_top_byte
);
  mlap_opnd_t x_q;
  mlap_opnd_t x_d;
  mlap_opnd_t y_q;
  mlap_opnd_t y_d;
  mlap_acc_t  acc_q;
  mlap_acc_t  acc_d;
  mlap_prod_t prod;
  mlap_prod_t product_q;
  logic [7:0] rdata_d;

  // One result byte of the accumulator, picked by its lowest bit position
  function automatic logic [7:0] acc_byte(mlap_acc_t acc, logic [4:0] lsb);
    return 8'(acc >> lsb);
  endfunction : acc_byte

  // Address decode, shared by the strobes, the read mux and the hit flag
  wire sel_multiply_only_x_operand = (reg_addr == `MLAP_ADDR_MULTIPLY_ONLY_X_OPERAND);
  wire sel_multiply_only_y_operand = (reg_addr == `MLAP_ADDR_MULTIPLY_ONLY_Y_OPERAND);
  wire sel_acc1  = (reg_addr == `MLAP_ADDR_ACC1_X);
  wire sel_acc0  = (reg_addr == `MLAP_ADDR_ACC0_Y);
  wire sel_clr   = (reg_addr == `MLAP_ADDR_CLR_A) || (reg_addr == `MLAP_ADDR_CLR_B);

  // Write strobes
  wire wr_multiply_only_x_operand  = reg_wr && sel_multiply_only_x_operand;
  wire wr_multiply_only_y_operand  = reg_wr && sel_multiply_only_y_operand;
  wire wr_accumulate_x_operand  = reg_wr && sel_acc1;
  wire wr_accumulate_y_operand  = reg_wr && sel_acc0;
  wire wr_clr    = reg_wr && sel_clr;
  wire wr_mac    = wr_accumulate_x_operand || wr_accumulate_y_operand;

  // Shared operand registers: either location of a pair loads the same flop
  assign x_d = (wr_multiply_only_x_operand || wr_accumulate_x_operand) ? mlap_opnd_t'(reg_wdata) : x_q;
  assign y_d = (wr_multiply_only_y_operand || wr_accumulate_y_operand) ? mlap_opnd_t'(reg_wdata) : y_q;

  // Product of the freshly written operands, so the step uses the new value
  mlap_mult u_mult (
    .x    (x_d),
    .y    (y_d),
    .prod (prod)
  );

  // Clear outranks accumulate; addresses differ so both cannot coincide.
  // Plain 32-bit add: overflow wraps, nothing saturates and no flag is kept.
  assign acc_d = wr_clr ? mlap_acc_t'(`MLAP_ACC_RST) :
                 wr_mac ? acc_q + mlap_acc_t'(prod) :
                 acc_q;

  // Read mux; any other address reads as zero on this port
  assign rdata_d = sel_acc1 ? acc_byte(acc_q, `MLAP_BYTE1_LSB) :
                   sel_acc0 ? acc_byte(acc_q, `MLAP_BYTE0_LSB) :
                   `MLAP_RDATA_IDLE;

  // Operand flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      x_q <= mlap_opnd_t'(`MLAP_OPND_RST);
      y_q <= mlap_opnd_t'(`MLAP_OPND_RST);
    end else begin
      x_q <= x_d;
      y_q <= y_d;
    end
  end

  // Accumulator
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= mlap_acc_t'(`MLAP_ACC_RST);
    end else begin
      acc_q <= acc_d;
    end
  end

  // Read data holds its last value between reads
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `MLAP_RDATA_IDLE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // Plain product kept in a flop, loaded on the same edge as the operands,
  // so it always equals x_q times y_q and needs no second multiplier
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      product_q <= mlap_prod_t'(`MLAP_PROD_RST);
    end else begin
      product_q <= prod;
    end
  end

  // Exports to the rest of the unit
  assign mul_product      = product_q;
  assign reg_hit          = sel_acc1 || sel_acc0;
  assign accum_third_byte = acc_byte(acc_q, `MLAP_BYTE2_LSB);
  assign accum_top_byte   = acc_byte(acc_q, `MLAP_BYTE3_LSB);

  // Checks
  sequence mac_wr_s;
    reg_wr && (reg_addr == `MLAP_ADDR_ACC1_X || reg_addr == `MLAP_ADDR_ACC0_Y);
  endsequence

  sequence rd_low_s;
    reg_rd && reg_addr == `MLAP_ADDR_ACC0_Y;
  endsequence

  // Accumulate write with the low byte read on the very next edge
  sequence mac_then_rd_s;
    mac_wr_s ##1 rd_low_s;
  endsequence

  sequence stray_rd_s;
    reg_rd && !(reg_addr == `MLAP_ADDR_ACC1_X || reg_addr == `MLAP_ADDR_ACC0_Y);
  endsequence

  // Read path
  rd_high_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == `MLAP_ADDR_ACC1_X |=> reg_rdata == $past(acc_q[15:8]))
    else $error("byte one read wrong");

  rd_low_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == `MLAP_ADDR_ACC0_Y |=> reg_rdata == $past(acc_q[7:0]))
    else $error("byte zero read wrong");

  fresh_low_a: assert property (@(posedge mclk) disable iff (!nrst)
    mac_then_rd_s |=> reg_rdata == $past(acc_q[7:0]))
    else $error("fresh low byte wrong");

  unmapped_rd_a: assert property (@(posedge mclk) disable iff (!nrst)
    stray_rd_s |=> reg_rdata == `MLAP_RDATA_IDLE)
    else $error("stray read not zero");

  rdata_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");

  hit_decode_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_hit == (reg_addr == `MLAP_ADDR_ACC1_X || reg_addr == `MLAP_ADDR_ACC0_Y))
    else $error("hit flag wrong");

  rd_no_side_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && !reg_wr |=> $stable(acc_q) && $stable(x_q) && $stable(y_q))
    else $error("read changed state");

  // Operands
  x_load_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `MLAP_ADDR_ACC1_X |=> x_q == $past(reg_wdata))
    else $error("x operand not loaded");

  y_load_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `MLAP_ADDR_ACC0_Y |=> y_q == $past(reg_wdata))
    else $error("y operand not loaded");

  shared_x_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `MLAP_ADDR_MULTIPLY_ONLY_X_OPERAND |=> x_q == $past(reg_wdata) && $stable(acc_q))
    else $error("shared x wrong");

  shared_y_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_wr && reg_addr == `MLAP_ADDR_MULTIPLY_ONLY_Y_OPERAND |=> y_q == $past(reg_wdata) && $stable(acc_q))
    else $error("shared y wrong");

  x_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !(wr_multiply_only_x_operand || wr_accumulate_x_operand) |=> $stable(x_q))
    else $error("x operand moved");

  y_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !(wr_multiply_only_y_operand || wr_accumulate_y_operand) |=> $stable(y_q))
    else $error("y operand moved");

  // Accumulator and product
  mac_step_a: assert property (@(posedge mclk) disable iff (!nrst)
    mac_wr_s |=> acc_q == $past(acc_q) + mlap_acc_t'(mlap_prod_t'(x_q) * mlap_prod_t'(y_q)))
    else $error("accumulate step wrong");

  wrap_sum_a: assert property (@(posedge mclk) disable iff (!nrst)
    mac_wr_s |=> acc_q == 32'(33'($past(acc_q)) + 33'(mlap_prod_t'(x_q) * mlap_prod_t'(y_q))))
    else $error("accumulator did not wrap");

  acc_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !reg_wr |=> $stable(acc_q))
    else $error("accumulator moved");

  clear_acc_a: assert property (@(posedge mclk) disable iff (!nrst)
    wr_clr |=> acc_q == `MLAP_ACC_RST)
    else $error("clear failed");

  clear_ops_a: assert property (@(posedge mclk) disable iff (!nrst)
    wr_clr |=> $stable(x_q) && $stable(y_q))
    else $error("clear touched operands");

  signed_prod_a: assert property (@(posedge mclk) disable iff (!nrst)
    mul_product == mlap_prod_t'(x_q) * mlap_prod_t'(y_q))
    else $error("product not signed");

  upper_export_a: assert property (@(posedge mclk) disable iff (!nrst)
    {accum_top_byte, accum_third_byte} == acc_q[31:16])
    else $error("upper bytes wrong");
endmodule : mlap_top

// [sim/tb_mlap_top.sv]
// Purpose: self-checking bench for the low accumulator port
// Assumes: one-cycle strobes driven on the falling edge
// Notes:   wrap past 32 bits left to the design's own assertions
`timescale 1ns/10ps
module tb_mlap_top;
  import mlap_pkg::*;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, accum_third_byte, accum_top_byte;
  logic       reg_hit;
  mlap_prod_t mul_product;
  int         err_count = 0;
  int         checked = 0;
  mlap_top dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .mul_product(mul_product), .accum_third_byte(accum_third_byte),
    .accum_top_byte(accum_top_byte));
  initial forever #2 mclk = ~mclk;
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  // Data is registered, so it is judged one edge after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(what, {8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd
  task automatic t_reset;
    rd(8'hec, 8'h00, "reset byte1");
    rd(8'hed, 8'h00, "reset byte0");
  endtask : t_reset
  // Only the two accumulate locations claim the bus
  task automatic t_hit;
    logic [7:0] addrs [3] = '{8'hec, 8'hed, 8'hee};
    foreach (addrs[i]) begin
      @(negedge mclk);
      reg_addr = addrs[i];
      @(posedge mclk);
      chk("hit", {15'h0000, reg_hit}, {15'h0000, (i < 2)});
    end
  endtask : t_hit
  task automatic t_accum;
    wr(8'he8, 8'h03);
    wr(8'hed, 8'hfe);
    rd(8'hed, 8'hfa, "acc byte0");
    rd(8'hec, 8'hff, "acc byte1");
    chk("top byte", {8'h00, accum_top_byte}, 16'h00ff);
    chk("third byte", {8'h00, accum_third_byte}, 16'h00ff);
    chk("product", mul_product, 16'hfffa);
  endtask : t_accum
  // Operand written through the accumulate location also feeds the plain product
  task automatic t_shared;
    wr(8'hec, 8'h80);
    rd(8'hec, 8'h00, "byte1 not operand");
    chk("shared x", mul_product, 16'h0100);
    wr(8'he9, 8'h01);
    chk("shared y", mul_product, 16'hff80);
    rd(8'hed, 8'hfa, "no acc on plain");
    rd(8'hee, 8'h00, "unmapped read");
  endtask : t_shared
  task automatic t_clear;
    logic [7:0] clr [2] = '{8'he6, 8'he7};
    foreach (clr[i]) begin
      wr(8'hed, 8'h05);
      chk("neg top", {8'h00, accum_top_byte}, 16'h00ff);
      wr(clr[i], 8'h5a);
      rd(8'hed, 8'h00, "cleared byte0");
      chk("cleared top", {8'h00, accum_top_byte}, 16'h0000);
      chk("cleared third", {8'h00, accum_third_byte}, 16'h0000);
    end
  endtask : t_clear
  // Reset in mid-run clears all; a write on the first edge after it lands
  task automatic t_midreset;
    wr(8'he8, 8'h07);
    wr(8'hed, 8'h09);
    rd(8'hed, 8'h3f, "pre-reset byte0");
    @(negedge mclk);
    nrst = 1'b0;
    @(negedge mclk);
    chk("rst rdata", {8'h00, reg_rdata}, 16'h0000);
    chk("rst product", mul_product, 16'h0000);
    chk("rst top", {8'h00, accum_top_byte}, 16'h0000);
    nrst = 1'b1;
    reg_addr = 8'he9;
    reg_wdata = 8'h04;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    wr(8'hec, 8'h02);
    rd(8'hed, 8'h08, "first write after reset");
    chk("product after reset", mul_product, 16'h0008);
  endtask : t_midreset
  // Low byte read on the edge straight after an accumulate write
  task automatic t_b2b;
    @(negedge mclk);
    reg_addr = 8'hed;
    reg_wdata = 8'h03;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("b2b byte0", {8'h00, reg_rdata}, 16'h000e);
    chk("b2b product", mul_product, 16'h0006);
  endtask : t_b2b
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    #20000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_hit();
    t_accum();
    t_shared();
    t_clear();
    t_midreset();
    t_b2b();
    print_verdict();
  end
endmodule : tb_mlap_top
